// ### logic/xlate_pkg.sv
// package: address translation field layouts, vectors and reset values
package xlate_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int EA_W        = 32;   // effective address width
    localparam int PA_W        = 36;   // physical address width
    localparam int SEG_NUM     = 16;   // on-chip segment registers
    localparam int SEG_IDX_W   = 4;    // segment select width
    localparam int SID_W       = 24;   // segment identifier width
    localparam int VPN_W       = 52;   // virtual page number width
    localparam int MASK_W      = 11;   // base size mask width
    localparam int XMASK_W     = 15;   // extended size mask width
    localparam int UMASK_W     = 4;    // upper size mask width
    localparam int REGIONS     = 4;    // region entries per side
    localparam int RIDX_W      = 2;    // region index width
    localparam int OFF_LOW_W   = 17;   // low block offset width
    localparam int RPN_W       = 20;   // page physical number width
    // ****************************************
    // region upper register fields (msb-0 bit k -> lsb 31-k)
    // ****************************************
    localparam int RU_EPI_LSB  = 17;   // effective page index bits 0-14
    localparam int RU_UM_LSB   = 13;   // upper size mask bits 15-18
    localparam int RU_MASK_LSB = 2;    // size mask bits 19-29
    localparam int RU_SV_BIT   = 1;    // supervisor valid, bit 30
    localparam int RU_UV_BIT   = 0;    // user valid, bit 31
    // ****************************************
    // region lower register fields
    // ****************************************
    localparam int RL_PPG_LSB  = 17;   // physical page bits 0-14
    localparam int RL_UPB_LSB  = 9;    // upper phys bits 20-22
    localparam int RL_B3_BIT   = 2;    // phys bit 3, bit 29
    // ****************************************
    // segment register and page entry fields
    // ****************************************
    localparam int SR_DS_BIT   = 31;   // direct-store flag, bit 0
    localparam int PE0_V_BIT   = 31;   // valid, bit 0
    localparam int PE0_SID_LSB = 7;    // identifier bits 1-24
    localparam int PE0_H_BIT   = 6;    // hash selector bit 25
    localparam int PE0_API_LSB = 0;    // abbreviated index bits 26-31
    localparam int PE1_RPN_LSB = 12;   // physical page bits 0-19
    localparam int PE1_UPB_LSB = 9;    // upper phys bits 20-22
    localparam int PE1_B3_BIT  = 2;    // phys bit 3, bit 29
    // ****************************************
    // fault vectors and reset values
    // ****************************************
    localparam logic [19:0] DATA_FAULT_VEC  = 20'h00300; // data storage fault
    localparam logic [19:0] INSTR_FAULT_VEC = 20'h00400; // instr storage fault
    localparam logic [3:0]  UMASK_RST       = 4'h0;      // upper mask reset
    localparam logic [31:0] WORD_RST        = 32'h0;     // register reset
    typedef enum logic [1:0] {SRC_NONE, SRC_REGION, SRC_PAGE} src_t;
endpackage

// ### logic/seg_regfile.sv
// segment register file: 16 words, registered read
`timescale 1ns/1ps
module seg_regfile #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clock,     // core clock
    input  wire logic          rst_n,     // async reset, active low
    input  wire logic          wr_en,     // write strobe
    input  wire logic [AW-1:0] wr_idx,    // write index
    input  wire logic [31:0]   wr_data,   // write word
    input  wire logic [AW-1:0] rd_idx,    // read index
    output logic      [31:0]   rd_data    // registered read word
);
    logic [31:0] mem_q [DEPTH];           // storage words

    // ****************************************
    // storage, one generate entry per word
    // ****************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        // write the addressed word
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= xlate_pkg::WORD_RST;
            end else if (wr_en && wr_idx == AW'(i)) begin
                mem_q[i] <= wr_data;
            end
        end
    end

    // registered read port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= xlate_pkg::WORD_RST;
        end else begin
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule

// ### logic/address_translation_unit.sv
// address translation unit: region and segment/page paths, wishbone regs
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// - base size mask is right-justified ones
// - hit needs masked match and valid
// - mask lsb at ea 14, clears bits
// - wide mode gives 36-bit block address
// - ea under mask ORs physical page
// - lower reg bits 0-3 give pa 4-7
// - upper phys bits, bit3 to pa 0-3
// - large mode widens mask to 15
// - upper mask keeps startup value
// - 15-bit mask right-justified ones
// - large mode compares 15-bit index
// - large wide hit forms pa 4-18
// - region hit overrides page path
// - ea 0-3 selects segment register
// - identifier plus ea 4-19 form vpn
// - page miss requests table search
// - page upper bits give pa 0-3
// - ea 20-31 copy to pa 24-35
// - direct-store segment raises storage fault
// - decode page entry word zero
// - decode page entry word one
// - upper mask zero without large mode
// - upper reg valid bits 30, 31
// - narrow mode zeroes pa 0-3
// ****************************************
module address_translation_unit #(
    parameter int REGIONS = 4
) (
    input  wire logic        clock,          // core clock, 10 MHz
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic [31:0] wb_adr_i,       // wishbone address
    input  wire logic [31:0] wb_dat_i,       // wishbone write data
    output logic      [31:0] wb_dat_o,       // wishbone read data
    input  wire logic        wb_we_i,        // wishbone write enable
    input  wire logic [3:0]  wb_sel_i,       // wishbone byte selects
    input  wire logic        wb_stb_i,       // wishbone strobe
    input  wire logic        wb_cyc_i,       // wishbone cycle
    output logic             wb_ack_o,       // wishbone ack
    input  wire logic        req_valid,      // translation request
    input  wire logic        req_instr,      // 1 fetch, 0 data access
    input  wire logic [31:0] req_ea,         // effective address
    input  wire logic        problem_state,  // user mode
    input  wire logic        page_hit,       // lookaside buffer hit
    input  wire logic [31:0] page_word0,     // page entry word 0
    input  wire logic [31:0] page_word1,     // page entry word 1
    output logic             rsp_valid,      // result pulse
    output logic [35:0]      rsp_pa,         // physical address
    output logic             rsp_region,     // region path used
    output logic             rsp_fault,      // storage fault
    output logic [19:0]      rsp_vector,     // fault vector
    output logic             rsp_search,     // table search needed
    output logic [51:0]      rsp_vpn,        // virtual page number
    output logic [5:0]       rsp_api,        // abbreviated page index
    output logic [3:0]       rsp_ext_abbrev_page_index        // extended abbreviated index
);
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] A_CFG   = 8'h00;  // configuration
    localparam logic [7:0] A_STAT  = 8'h04;  // status
    localparam logic [7:0] A_RU    = 8'h40;  // region upper, stride 8
    localparam logic [7:0] A_RL    = 8'h44;  // region lower, stride 8
    localparam logic [7:0] A_SEG   = 8'h80;  // segment regs, stride 4

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ru_q [REGIONS];             // region upper words
    logic [31:0] rl_q [REGIONS];             // region lower words
    logic        wide_addr_enable_q;         // 36-bit addressing
    logic        large_region_enable_q;      // large-region mode
    logic        large_at_start_q;           // large mode at startup
    logic        started_q;                  // startup latch done
    logic        ack_q;                      // bus ack
    logic        busy_q;                     // request in flight
    logic [31:0] ea_q;                       // held address
    logic        instr_q;                    // held fetch flag
    logic [31:0] last_pa_q;                  // status: last low pa
    logic        last_fault_q;               // status: last fault

    // ****************************************
    // bus decode
    // ****************************************
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        bus_wr   = bus_req & wb_we_i;
    wire [7:0]  adr      = wb_adr_i[7:0];
    wire        hit_cfg  = adr == A_CFG;
    wire        hit_stat = adr == A_STAT;
    wire        hit_rgn  = adr[7:6] == A_RU[7:6] && adr[5:3] < 3'(REGIONS)
                           && adr[1:0] == 2'b00;
    wire [1:0]  rgn_idx  = adr[4:3];
    wire        rgn_low  = adr[2];
    wire        hit_seg  = adr[7:6] == A_SEG[7:6] && adr[1:0] == 2'b00;
    wire [3:0]  seg_widx = adr[5:2];
    wire        seg_we   = bus_wr & hit_seg;
    wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ****************************************
    // segment register storage
    // ****************************************
    wire [3:0]  seg_ridx = busy_q ? ea_q[31:28] : req_ea[31:28];
    logic [31:0] seg_word;                   // selected descriptor
    seg_regfile #(
        .DEPTH (xlate_pkg::SEG_NUM),
        .AW    (xlate_pkg::SEG_IDX_W)
    ) u_seg (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (seg_we),
        .wr_idx  (seg_widx),
        .wr_data (wb_dat_i),
        .rd_idx  (seg_ridx),
        .rd_data (seg_word)
    );

    // ****************************************
    // region compare, one generate entry each
    // ****************************************
    logic [REGIONS-1:0] rgn_hit;              // per-entry hit
    logic [35:0]        rgn_pa [REGIONS];     // per-entry address
    for (genvar r = 0; r < REGIONS; r++) begin : g_rgn
        wire [3:0]  um   = large_region_enable_q ?
                           ru_q[r][16:13] : 4'h0;
        wire [14:0] mask = {um, ru_q[r][12:2]};
        wire [14:0] ea_hi = ea_q[31:17];
        wire        valid = problem_state ? ru_q[r][0]
                                          : ru_q[r][1];
        // mask lsb sits on ea bit 14, ones clear compared bits
        assign rgn_hit[r] = ((ea_hi & ~mask) == ru_q[r][31:17])
                            && valid;
        // bits under ones are block offset, rest OR physical page
        wire [14:0] hi = (ea_hi & mask) | rl_q[r][31:17];
        wire [3:0]  top = {rl_q[r][11:9], rl_q[r][2]};
        assign rgn_pa[r] = {wide_addr_enable_q ? top : 4'h0,
                            hi, ea_q[16:0]};
    end

    // first hitting entry, overlap is a software error
    logic        any_hit;
    logic [35:0] sel_pa;
    always_comb begin
        any_hit = 1'b0;
        sel_pa  = 36'h0;
        for (int i = REGIONS - 1; i >= 0; i--) begin
            if (rgn_hit[i]) begin
                any_hit = 1'b1;
                sel_pa  = rgn_pa[i];
            end
        end
    end

    // ****************************************
    // segment / page path
    // ****************************************
    wire [23:0] sid      = seg_word[23:0];
    wire        dstore   = seg_word[xlate_pkg::SR_DS_BIT];
    wire [51:0] virtual_page_number      = {12'h000, sid, ea_q[27:12]};
    wire        pe_valid = page_word0[xlate_pkg::PE0_V_BIT];
    wire [23:0] pe_sid   = page_word0[30:7];
    wire [5:0]  pe_api   = page_word0[5:0];
    wire [19:0] pe_rpn   = page_word1[31:12];
    wire [3:0]  pe_top   = {page_word1[11:9],
                            page_word1[xlate_pkg::PE1_B3_BIT]};
    wire        pe_match = page_hit & pe_valid & (pe_sid == sid)
                           & (pe_api == ea_q[27:22]);
    wire [35:0] page_pa  = {wide_addr_enable_q ? pe_top : 4'h0,
                            pe_rpn, ea_q[11:0]};

    // ****************************************
    // request sequencing: take, then answer
    // ****************************************
    // request held one cycle so the segment read is registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_q  <= 1'b0;
            ea_q    <= xlate_pkg::WORD_RST;
            instr_q <= 1'b0;
        end else begin
            busy_q <= req_valid & ~busy_q;
            if (req_valid && !busy_q) begin
                ea_q    <= req_ea;
                instr_q <= req_instr;
            end
        end
    end

    // result registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid  <= 1'b0;
            rsp_pa     <= 36'h0;
            rsp_region <= 1'b0;
            rsp_fault  <= 1'b0;
            rsp_vector <= 20'h0;
            rsp_search <= 1'b0;
            rsp_vpn    <= 52'h0;
            rsp_api    <= 6'h0;
            rsp_ext_abbrev_page_index   <= 4'h0;
        end else begin
            rsp_valid  <= busy_q;
            if (busy_q) begin
                rsp_region <= any_hit;
                rsp_vpn    <= virtual_page_number;
                rsp_api    <= ea_q[27:22];
                rsp_ext_abbrev_page_index   <= ea_q[21:18];
                if (any_hit) begin
                    rsp_pa     <= sel_pa;
                    rsp_fault  <= 1'b0;
                    rsp_vector <= 20'h0;
                    rsp_search <= 1'b0;
                end else if (dstore) begin
                    rsp_pa     <= 36'h0;
                    rsp_fault  <= 1'b1;
                    rsp_vector <= instr_q ? xlate_pkg::INSTR_FAULT_VEC
                                          : xlate_pkg::DATA_FAULT_VEC;
                    rsp_search <= 1'b0;
                end else begin
                    rsp_pa     <= pe_match ? page_pa : 36'h0;
                    rsp_fault  <= 1'b0;
                    rsp_vector <= 20'h0;
                    rsp_search <= ~pe_match;
                end
            end
        end
    end

    // status capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_pa_q    <= xlate_pkg::WORD_RST;
            last_fault_q <= 1'b0;
        end else if (rsp_valid) begin
            last_pa_q    <= rsp_pa[31:0];
            last_fault_q <= rsp_fault;
        end
    end

    // ****************************************
    // configuration and startup capture
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wide_addr_enable_q    <= 1'b0;
            large_region_enable_q <= 1'b0;
            large_at_start_q      <= 1'b0;
            started_q             <= 1'b0;
        end else begin
            // first config write fixes the startup large mode
            if (bus_wr && hit_cfg && wb_sel_i[0]) begin
                wide_addr_enable_q    <= wb_dat_i[0];
                large_region_enable_q <= wb_dat_i[1];
                started_q             <= 1'b1;
                if (!started_q) begin
                    large_at_start_q <= wb_dat_i[1];
                end
            end
        end
    end

    // ****************************************
    // region registers
    // ****************************************
    for (genvar r = 0; r < REGIONS; r++) begin : g_rreg
        wire wr_u = bus_wr & hit_rgn & ~rgn_low & (rgn_idx == 2'(r));
        wire wr_l = bus_wr & hit_rgn &  rgn_low & (rgn_idx == 2'(r));
        wire [31:0] nu = (ru_q[r] & ~wmask) | (wb_dat_i & wmask);
        // upper mask writable only if large mode was on at startup
        wire [3:0]  nu_um = large_at_start_q ? nu[16:13]
                                             : xlate_pkg::UMASK_RST;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                ru_q[r] <= xlate_pkg::WORD_RST;
                rl_q[r] <= xlate_pkg::WORD_RST;
            end else begin
                if (wr_u) begin
                    ru_q[r] <= {nu[31:17], nu_um, nu[12:0]};
                end
                if (wr_l) begin
                    rl_q[r] <= (rl_q[r] & ~wmask) | (wb_dat_i & wmask);
                end
            end
        end
    end

    // ****************************************
    // bus read mux and ack
    // ****************************************
    wire [31:0] rgn_rd  = rgn_low ? rl_q[rgn_idx] : ru_q[rgn_idx];
    wire [31:0] cfg_rd  = {29'h0, large_at_start_q,
                           large_region_enable_q, wide_addr_enable_q};
    wire [31:0] stat_rd = {last_fault_q, last_pa_q[30:0]};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q    <= 1'b0;
            wb_dat_o <= xlate_pkg::WORD_RST;
        end else begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= hit_cfg  ? cfg_rd :
                            hit_stat ? stat_rd :
                            hit_rgn  ? rgn_rd : 32'h0;
            end
        end
    end
    assign wb_ack_o = ack_q;
endmodule

// ### test/atu_sva.sv
// checker: port timing and field relations
`timescale 1ns/1ps
module atu_sva (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        req_valid,
    input wire logic        req_instr,
    input wire logic [31:0] req_ea,
    input wire logic        page_hit,
    input wire logic        rsp_valid,
    input wire logic [35:0] rsp_pa,
    input wire logic        rsp_region,
    input wire logic        rsp_fault,
    input wire logic [19:0] rsp_vector,
    input wire logic        rsp_search,
    input wire logic [5:0]  rsp_api,
    input wire logic [3:0]  rsp_ext_abbrev_page_index
);
    logic [31:0] ea_q;    // address of the request in flight
    logic        instr_q; // kind of the request in flight
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ********
    // capture of the request in flight
    // ********
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ea_q    <= 32'h0;
            instr_q <= 1'b0;
        end else if (req_valid) begin
            ea_q    <= req_ea;
            instr_q <= req_instr;
        end
    end
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_rsp_after_take: assert property (req_valid && !$past(req_valid) |-> ##2 rsp_valid)
        else $error("result late");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid, 2) ##1 !rsp_valid)
        else $error("stray result");
    a_region_low_offset: assert property (rsp_valid && rsp_region |-> rsp_pa[16:0] == ea_q[16:0])
        else $error("block offset wrong");
    a_region_wins_path: assert property (rsp_valid && rsp_region |-> !rsp_fault && !rsp_search)
        else $error("page path on block hit");
    a_page_byte_offset: assert property (rsp_valid && !rsp_region && !rsp_fault && !rsp_search
        |-> rsp_pa[11:0] == ea_q[11:0]) else $error("page offset wrong");
    a_index_fields_ok: assert property (rsp_valid && !rsp_region && !rsp_fault
        |-> {rsp_api, rsp_ext_abbrev_page_index} == ea_q[27:18]) else $error("index fields wrong");
    a_fault_vector_kind: assert property (rsp_valid && rsp_fault |-> rsp_vector ==
        (instr_q ? xlate_pkg::INSTR_FAULT_VEC : xlate_pkg::DATA_FAULT_VEC))
        else $error("fault vector wrong");
    a_miss_asks_search: assert property (rsp_valid && !rsp_region && !rsp_fault
        && !$past(page_hit) |-> rsp_search) else $error("no search on miss");
    c_region_hit: cover property (rsp_valid && rsp_region);
    c_fault: cover property (rsp_valid && rsp_fault);
    c_search: cover property (rsp_valid && rsp_search);
endmodule
bind address_translation_unit atu_sva chk_i (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_valid(req_valid),
    .req_instr(req_instr), .req_ea(req_ea), .page_hit(page_hit), .rsp_valid(rsp_valid),
    .rsp_pa(rsp_pa), .rsp_region(rsp_region), .rsp_fault(rsp_fault),
    .rsp_vector(rsp_vector), .rsp_search(rsp_search), .rsp_api(rsp_api),
    .rsp_ext_abbrev_page_index(rsp_ext_abbrev_page_index));

// ### test/lookaside_model.sv
// partner: lookaside buffer answering the cycle after each request
`timescale 1ns/1ps
module lookaside_model (
    input  wire logic        clock,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_ea,
    input  wire logic [23:0] sid,
    input  wire logic [19:0] physical_page_number,
    input  wire logic [3:0]  xbits,
    input  wire logic        miss,
    output logic             page_hit,
    output logic      [31:0] page_word0,
    output logic      [31:0] page_word1
);
    initial {page_hit, page_word0, page_word1} = '0;
    // entry for one cycle, then scrambled
    always @(posedge clock) begin
        if (req_valid) begin
            page_hit   <= !miss;
            page_word0 <= {1'b1, sid, 1'b0, req_ea[27:22]};
            page_word1 <= {physical_page_number, xbits[3:1], 6'h00, xbits[0], 2'h2};
        end else begin
            page_hit   <= ~page_hit;
            page_word0 <= ~page_word0;
            page_word1 <= ~page_word1;
        end
    end
endmodule

// ### test/tb_top.sv
// testbench: register setup over wishbone, random translations vs reference
`timescale 1ns/1ps
module tb_top;
    logic        clock, rst_n, cyc, stb, we, ack, req_valid, req_instr, problem_state;
    logic        miss, page_hit, rsp_valid, rsp_region, rsp_fault, rsp_search;
    logic [31:0] adr, wdat, rdat, req_ea, page_word0, page_word1, q;
    logic [35:0] rsp_pa;
    logic [19:0] rsp_vector, physical_page_number;
    logic [51:0] rsp_vpn;
    logic [5:0]  rsp_api;
    logic [3:0]  rsp_ext_abbrev_page_index, xbits;
    logic [23:0] sid, seg_sid[16];
    logic [15:0] seg_ds;
    logic [14:0] epi[4], ppg[4];
    logic [10:0] msk[4];
    logic [3:0]  um[4];
    logic [2:0]  upb[4];
    logic [3:0]  b3, sv, uv;
    logic [31:0] base[6];
    logic        large_on, wide_on;
    int          n_mismatch, checks_done, seed;
    address_translation_unit address_translation_unit_i (.clock(clock), .rst_n(rst_n),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
        .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .req_valid(req_valid),
        .req_instr(req_instr), .req_ea(req_ea), .problem_state(problem_state),
        .page_hit(page_hit), .page_word0(page_word0), .page_word1(page_word1),
        .rsp_valid(rsp_valid), .rsp_pa(rsp_pa), .rsp_region(rsp_region), .rsp_fault(rsp_fault),
        .rsp_vector(rsp_vector), .rsp_search(rsp_search), .rsp_vpn(rsp_vpn),
        .rsp_api(rsp_api), .rsp_ext_abbrev_page_index(rsp_ext_abbrev_page_index));
    lookaside_model lookaside_model_i (.clock(clock), .req_valid(req_valid), .req_ea(req_ea),
        .sid(sid), .physical_page_number(physical_page_number), .xbits(xbits), .miss(miss), .page_hit(page_hit),
        .page_word0(page_word0), .page_word1(page_word1));
    // ********
    // clock, watchdog and verdict
    // ********
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #3000000;
        n_mismatch++;
        finish_test();
    end
    task finish_test();
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ********
    // wishbone classic single cycle
    // ********
    task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {cyc, stb} <= 2'b11;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) n_mismatch++;
    endtask
    function automatic logic [31:0] upper(input int i);
        return {epi[i], um[i], msk[i], sv[i], uv[i]};
    endfunction
    // ********
    // one translation against the reference
    // ********
    task xl(input logic [31:0] ea, input logic [31:0] r);
        logic [35:0] epa;
        logic [14:0] m;
        logic        hit, ds;
        int          n;
        hit = 1'b0;
        ds = seg_ds[ea[31:28]];
        for (int i = 0; i < 4; i++) begin
            m = large_on ? {um[i], msk[i]} : {4'h0, msk[i]};
            if (!hit && ((ea[31:17] & ~m) == epi[i]) && (r[0] ? uv[i] : sv[i])) begin
                hit = 1'b1;
                epa = {upb[i], b3[i], (ea[31:17] & m) | ppg[i], ea[16:0]};
            end
        end
        @(posedge clock);
        req_valid <= 1'b1;
        req_ea <= ea;
        req_instr <= r[1];
        problem_state <= r[0];
        miss <= r[2];
        physical_page_number <= r[31:12];
        xbits <= r[7:4];
        sid <= seg_sid[ea[31:28]];
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 10);
        if (n >= 10) n_mismatch++;
        cmp(rsp_region, hit);
        if (hit) cmp(rsp_pa, {wide_on ? epa[35:32] : 4'h0, epa[31:0]});
        else if (!hit) begin
            cmp(rsp_fault, ds);
            if (ds) cmp(rsp_vector, r[1] ? 20'h00400 : 20'h00300);
            else begin
                cmp(rsp_search, r[2]);
                cmp({rsp_api, rsp_ext_abbrev_page_index, rsp_vpn}, {ea[27:18], 12'h0, seg_sid[ea[31:28]], ea[27:12]});
                if (!r[2]) cmp(rsp_pa, {wide_on ? r[7:4] : 4'h0, r[31:12], ea[11:0]});
            end
        end
    endtask
    task run();
        logic [31:0] r1;
        int          k;
        for (int i = 0; i < 30; i++) begin
            r1 = $random(seed);
            k = {r1} % 7;
            xl(k == 6 ? r1 : base[k % 6] ^ (r1 & 32'h000F_FFFF), $random(seed));
        end
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        {rst_n, cyc, stb, we, req_valid, req_instr, problem_state, miss} = 8'h00;
        {adr, wdat, req_ea, physical_page_number, xbits, sid} = 0;
        {n_mismatch, checks_done} = 0;
        seed = 32'h1776a441;
        // blocks aligned: low page bits zero
        epi = '{15'h4000, 15'h0123, 15'h1230, 15'h2000};
        ppg = '{15'h4000, 15'h7ABC, 15'h5550, 15'h1111};
        msk = '{11'h7FF, 11'h000, 11'h00F, 11'h000};
        um = '{4'h7, 4'h0, 4'h0, 4'h0};
        upb = '{3'h5, 3'h2, 3'h7, 3'h1};
        {b3, sv, uv} = 12'h556;
        base = '{32'h8000_0000, 32'h0246_0000, 32'h2460_0000, 32'h4000_0000,
            32'hB000_0000, 32'hC000_0000};
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        wb(1'b0, 32'h0, 32'h0);
        cmp(q, 32'h0);
        wb(1'b0, 32'h200, 32'h0);
        cmp(q, 32'h0);
        wb(1'b1, 32'h0, 32'h3);
        wb(1'b0, 32'h0, 32'h0);
        cmp(q, 32'h7);
        {large_on, wide_on} = 2'b11;
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 32'h40 + 8 * i, upper(i % 4));
            wb(1'b1, 32'h44 + 8 * i, {ppg[i % 4], 5'h0, upb[i % 4], 6'h00, b3[i % 4], 2'h2});
        end
        for (int s = 0; s < 16; s++) begin
            seg_sid[s] = $random(seed);
            seg_ds[s] = (s == 12);
            wb(1'b1, 32'h80 + 4 * s, {seg_ds[s], 7'h00, seg_sid[s]});
        end
        wb(1'b0, 32'h80, 32'h0);
        cmp(q, 32'h0);
        run();
        wb(1'b1, 32'h0, 32'h1);
        large_on = 1'b0;
        wb(1'b0, 32'h40, 32'h0);
        cmp(q, upper(0));
        run();
        wb(1'b1, 32'h0, 32'h0);
        wide_on = 1'b0;
        run();
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        wb(1'b1, 32'h0, 32'h1);
        wb(1'b1, 32'h40, upper(0));
        wb(1'b0, 32'h40, 32'h0);
        cmp(q, upper(0) & 32'hFFFF_1FFF);
        finish_test();
    end
endmodule
